// [rtl/mpg_map.vh]
// Purpose: constants for the external mii port and general purpose pins
// Assumes: byte-wide register port on the local cpu bus
// Notes:   offsets are register indexes on the local address lines
`ifndef MPG_MAP_VH
`define MPG_MAP_VH
`define MPG_OFS_MGMT        5'h14
`define MPG_OFS_GPIO        5'h17
`define MPG_OFS_PORTSEL     5'h1b
`define MPG_MGMT_MDC_BIT    0
`define MPG_MGMT_MDO_BIT    1
`define MPG_MGMT_MDOE_BIT   2
`define MPG_MGMT_MDI_BIT    3
`define MPG_GPIO_SPD_BIT    6
`define MPG_GPIO_DPX_BIT    5
`define MPG_GPIO_LINK_BIT   4
`define MPG_GPIO_GPO_BIT    0
`define MPG_PORTSEL_PP_BIT  0
`define MPG_GPO_WR_RESET    1'b0
`define MPG_MGMT_RESET      8'h00
`define MPG_PORTSEL_RESET   8'h00
`endif

// [rtl/mpg_port.v]
// Purpose: external mii port datapath, management pins and general purpose pins
// Assumes: clock at 100 mhz, mii clocks at 25 mhz or below, sampled as data
// Notes:   tx nibble stream uses valid/ready, rx stream is a one-cycle strobe
`include "mpg_map.vh"
module mpg_port (
	input  wire       clock,               // core clock
	input  wire       srst,                // synchronous reset, high
	input  wire       cs_n,                // chip select, low
	input  wire       iord_n,              // read strobe, low
	input  wire       iowr_n,              // write strobe, low
	input  wire [4:0] addr,                // register index
	input  wire [7:0] wdata,               // write data
	output reg  [7:0] rdata,               // read data
	input  wire       tx_clk,              // phy transmit clock
	output reg        tx_en,               // transmit enable
	output reg  [3:0] txd,                 // transmit nibble
	input  wire       rx_clk,              // phy receive clock
	input  wire       rx_dv,               // receive data valid
	input  wire [3:0] rxd,                 // receive nibble
	input  wire       crs,                 // carrier sense
	input  wire       col,                 // collision
	output wire       mdc,                 // management clock
	input  wire       mdio_i,              // management data in
	output wire       mdio_o,              // management data out
	output wire       mdio_oe,             // management data drive enable
	input  wire       speed_status_input,  // speed status pin
	input  wire       duplex_status_input, // duplex / media empty pin
	input  wire       link_status_input,   // link / printer online pin
	output wire       general_output_zero, // general purpose output
	output wire       printer_port,        // printer port selected
	output wire       media_empty_input,   // duplex pin seen as media empty
	output wire       printer_online_input,// link pin seen as printer online
	input  wire       tx_valid,            // nibble offered to send
	input  wire [3:0] tx_data,             // nibble to send
	input  wire       tx_last,             // last nibble of frame
	output wire       tx_ready,            // nibble taken this cycle
	output reg        rx_valid,            // received nibble strobe
	output reg  [3:0] rx_data,             // received nibble
	output reg        rx_frame,            // receive frame active level
	output wire       carrier,             // synchronized carrier sense
	output wire       collision            // synchronized collision, held low in full duplex
);
	// three-stage synchronizers, change counted once stages 2 and 3 agree
	reg  [2:0] s_txc_r, s_rxc_r, s_crs_r, s_col_r, s_spd_r, s_dpx_r, s_lnk_r, s_mdi_r;
	reg  [2:0] s_dv_r;                     // rx valid
	reg  [3:0] s_rd1_r, s_rd2_r, s_rd3_r;  // rx data stages
	reg        txc_q_r, rxc_q_r;           // filtered clock levels
	reg        crs_q_r, col_q_r;           // filtered status
	reg        spd_q_r, dpx_q_r, lnk_q_r;  // filtered gp inputs
	reg        mdi_q_r;                    // filtered management data
	reg        gpo_wr_r;                   // last value written to gpo bit
	reg  [7:0] mgmt_r;                     // management register
	reg  [7:0] psel_r;                     // port select register
	reg        wr_d_r;                     // delayed write strobe
	reg        tx_last_r;                  // final nibble now on pins
	wire       wr_act;                     // write strobe asserted
	wire       wr_edge;                    // start of write strobe
	wire       txc_rise;                   // tx clock rising edge
	wire       rxc_rise;                   // rx clock rising edge

	// a value agreeing in stages 2 and 3 is treated as settled
	function filt;
		input [2:0] s;
		input       q;
		begin
			filt = (s[1] == s[2]) ? s[2] : q;
		end
	endfunction

	// synchronize every pin input with three flops
	always @(posedge clock)
	begin
		if (srst)
		begin
			s_txc_r <= 3'h0;
			s_rxc_r <= 3'h0;
			s_crs_r <= 3'h0;
			s_col_r <= 3'h0;
			s_spd_r <= 3'h0;
			s_dpx_r <= 3'h0;
			s_lnk_r <= 3'h0;
			s_mdi_r <= 3'h0;
			s_dv_r  <= 3'h0;
			s_rd1_r <= 4'h0;
			s_rd2_r <= 4'h0;
			s_rd3_r <= 4'h0;
			txc_q_r <= 1'b0;
			rxc_q_r <= 1'b0;
			crs_q_r <= 1'b0;
			col_q_r <= 1'b0;
			spd_q_r <= 1'b0;
			dpx_q_r <= 1'b0;
			lnk_q_r <= 1'b0;
			mdi_q_r <= 1'b0;
		end
		else
		begin
			s_txc_r <= {s_txc_r[1:0], tx_clk};
			s_rxc_r <= {s_rxc_r[1:0], rx_clk};
			s_crs_r <= {s_crs_r[1:0], crs};
			s_col_r <= {s_col_r[1:0], col};
			s_spd_r <= {s_spd_r[1:0], speed_status_input};
			s_dpx_r <= {s_dpx_r[1:0], duplex_status_input};
			s_lnk_r <= {s_lnk_r[1:0], link_status_input};
			s_mdi_r <= {s_mdi_r[1:0], mdio_i};
			s_dv_r  <= {s_dv_r[1:0], rx_dv};
			s_rd1_r <= rxd;
			s_rd2_r <= s_rd1_r;
			s_rd3_r <= s_rd2_r;
			txc_q_r <= filt(s_txc_r, txc_q_r);
			rxc_q_r <= filt(s_rxc_r, rxc_q_r);
			crs_q_r <= filt(s_crs_r, crs_q_r);
			col_q_r <= filt(s_col_r, col_q_r);
			spd_q_r <= filt(s_spd_r, spd_q_r);
			dpx_q_r <= filt(s_dpx_r, dpx_q_r);
			lnk_q_r <= filt(s_lnk_r, lnk_q_r);
			mdi_q_r <= filt(s_mdi_r, mdi_q_r);
		end
	end

	// edges of the sampled link clocks; they assume the phy keeps them running
	assign txc_rise = (filt(s_txc_r, txc_q_r) == 1'b1) && !txc_q_r;
	assign rxc_rise = (filt(s_rxc_r, rxc_q_r) == 1'b1) && !rxc_q_r;

	// transmit: load one nibble per tx clock rise, pins move only then
	assign tx_ready = txc_rise && tx_valid && !(tx_last_r && tx_en);
	always @(posedge clock)
	begin
		if (srst)
		begin
			tx_en     <= 1'b0;
			txd       <= 4'h0;
			tx_last_r <= 1'b0;
		end
		else if (txc_rise)
		begin
			if (tx_ready)
			begin
				tx_en     <= 1'b1;
				txd       <= tx_data;
				tx_last_r <= tx_last;
			end
			else
			begin
				// underrun or end of frame closes the frame
				tx_en     <= 1'b0;
				txd       <= 4'h0;
				tx_last_r <= 1'b0;
			end
		end
	end

	// receive: take a nibble on rx clock rise only when valid is high
	// rx_er does not exist here, so errored frames pass unmarked
	always @(posedge clock)
	begin
		if (srst)
		begin
			rx_valid <= 1'b0;
			rx_data  <= 4'h0;
			rx_frame <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (rxc_rise)
			begin
				rx_frame <= s_dv_r[2];
				if (s_dv_r[2])
				begin
					rx_valid <= 1'b1;
					rx_data  <= s_rd3_r;
				end
			end
		end
	end

	assign carrier   = crs_q_r;
	assign collision = col_q_r && !dpx_q_r;

	// register writes on the leading edge of the write strobe
	assign wr_act  = !cs_n && !iowr_n;
	assign wr_edge = wr_act && !wr_d_r;
	always @(posedge clock)
	begin
		if (srst)
		begin
			wr_d_r   <= 1'b0;
			gpo_wr_r <= `MPG_GPO_WR_RESET;
			mgmt_r   <= `MPG_MGMT_RESET;
			psel_r   <= `MPG_PORTSEL_RESET;
		end
		else
		begin
			wr_d_r <= wr_act;
			if (wr_edge)
			begin
				case (addr)
					`MPG_OFS_GPIO:    gpo_wr_r <= wdata[`MPG_GPIO_GPO_BIT];
					`MPG_OFS_MGMT:    mgmt_r   <= wdata;
					`MPG_OFS_PORTSEL: psel_r   <= wdata;
					default:          gpo_wr_r <= gpo_wr_r;
				endcase
			end
		end
	end

	// software toggles mdc itself and must keep it slow enough
	assign mdc     = mgmt_r[`MPG_MGMT_MDC_BIT];
	assign mdio_o  = mgmt_r[`MPG_MGMT_MDO_BIT];
	assign mdio_oe = mgmt_r[`MPG_MGMT_MDOE_BIT];
	assign general_output_zero = ~gpo_wr_r;
	assign printer_port = psel_r[`MPG_PORTSEL_PP_BIT];
	assign media_empty_input    = printer_port & dpx_q_r;
	assign printer_online_input = printer_port & lnk_q_r;

	// read data registered while read strobe and select are low
	always @(posedge clock)
	begin
		if (srst)
			rdata <= 8'h00;
		else if (!cs_n && !iord_n)
		begin
			rdata <= 8'h00;
			case (addr)
				`MPG_OFS_GPIO:
				begin
					rdata[`MPG_GPIO_SPD_BIT]  <= spd_q_r;
					rdata[`MPG_GPIO_DPX_BIT]  <= dpx_q_r & !printer_port;
					rdata[`MPG_GPIO_LINK_BIT] <= lnk_q_r & !printer_port;
					rdata[`MPG_GPIO_GPO_BIT]  <= gpo_wr_r;
				end
				`MPG_OFS_MGMT:
					rdata <= {4'h0, mdi_q_r, mgmt_r[2:0]};
				`MPG_OFS_PORTSEL:
					rdata <= psel_r;
				default:
					rdata <= 8'h00;
			endcase
		end
	end
endmodule

// [sim/mpg_port_asserts.sv]
// Purpose: pin and register checks for mpg_port
// Assumes: one core clock domain, synchronous high reset
// Notes:   input filters settle well inside eight stable cycles
module mpg_port_asserts (
	input logic       clock,
	input logic       srst,
	input logic       cs_n,
	input logic       iord_n,
	input logic       iowr_n,
	input logic [4:0] addr,
	input logic [7:0] wdata,
	input logic [7:0] rdata,
	input logic       tx_clk,
	input logic       tx_en,
	input logic [3:0] txd,
	input logic       tx_ready,
	input logic [3:0] tx_data,
	input logic       rx_valid,
	input logic       rx_frame,
	input logic       crs,
	input logic       carrier,
	input logic       mdc,
	input logic       speed_status_input,
	input logic       general_output_zero
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// a write is taken once, at the first edge with the strobe low
	sequence s_wr(a);
		!cs_n && $fell(iowr_n) && addr == a;
	endsequence
	// a pin held still long enough to pass the filter
	sequence s_calm(x);
		($stable(x))[*8];
	endsequence
	a_gpo_reset: assert property ($fell(srst) |-> general_output_zero) else $error("gpo low after reset");
	a_gpo_write: assert property (s_wr(5'h17) |=> general_output_zero == !$past(wdata[0]))
		else $error("gpo bad");
	a_mdc_bit: assert property (s_wr(5'h14) |=> mdc == $past(wdata[0])) else $error("mdc bad");
	a_speed_read: assert property (s_calm(speed_status_input) ##0 (!cs_n && !iord_n && addr == 5'h17)
		|=> rdata[6] == $past(speed_status_input)) else $error("speed bit bad");
	a_tx_take: assert property (tx_ready |=> tx_en && txd == $past(tx_data)) else $error("tx nibble bad");
	a_tx_edge: assert property (!$stable({tx_en, txd}) |-> tx_clk) else $error("tx off edge");
	a_rx_pulse: assert property (rx_valid |-> rx_frame ##1 !rx_valid) else $error("rx strobe bad");
	a_carrier_sync: assert property (s_calm(crs) |-> carrier == crs) else $error("carrier bad");
endmodule
bind mpg_port mpg_port_asserts u_chk (.*);

// [sim/mpg_phy_model.sv]
// Purpose: behavioural phy on the far side of the mii
// Assumes: both mii clocks run free at 160 ns
// Notes:   mdio line idles high through its pull-up
module mpg_phy_model (
	output logic       tx_clk,
	input  logic       tx_en,
	input  logic [3:0] txd,
	output logic       rx_clk,
	output logic       rx_dv,
	output logic [3:0] rxd,
	input  logic       mdio_o,
	input  logic       mdio_oe,
	output logic       mdio_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] txq [0:15]; // nibbles accepted from the port
	int         tn = 0;
	initial
	begin
		tx_clk = 0;
		rx_clk = 0;
		rx_dv = 0;
		rxd = 4'hf;
		#37; // receive clock phase unrelated to transmit
		forever #80 rx_clk = ~rx_clk;
	end
	always #80 tx_clk = ~tx_clk;
	// accept one nibble per enabled transmit period
	always @(posedge tx_clk)
		if (tx_en === 1'b1 && tn < 16)
		begin
			txq[tn] = txd;
			tn++;
		end
	assign mdio_i = mdio_oe ? mdio_o : 1'b1;
	// send n nibbles qualified by data valid; they change on each fall
	// so they stand still across the rise at which the port samples them
	task send(input int n);
		for (int k = 0; k < n; k++)
		begin
			@(negedge rx_clk);
			rx_dv <= 1'b1;
			rxd <= 4'ha ^ k[3:0];
		end
		@(negedge rx_clk);
		rx_dv <= 1'b0;
		rxd <= 4'hf;
	endtask
endmodule

// [sim/mpg_port_tb.sv]
// Purpose: self-checking bench for mpg_port
// Assumes: strobes driven on the falling edge
// Notes:   every wait is bounded
module mpg_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, srst = 1, cs_n = 1, iord_n = 1, iowr_n = 1, crs = 0, col = 0;
	logic [4:0] addr = 0;
	logic [7:0] wdata = 0, rdata;
	logic speed_status_input = 1, duplex_status_input = 0, link_status_input = 1;
	logic tx_valid = 0, tx_last = 0, tx_ready, tx_en, tx_clk, rx_clk, rx_dv, rx_valid, rx_frame;
	logic [3:0] tx_data = 0, txd, rxd, rx_data;
	logic mdc, mdio_i, mdio_o, mdio_oe, general_output_zero, printer_port;
	logic media_empty_input, printer_online_input, carrier, collision;
	int failures = 0, comparisons = 0, rn = 0, i;
	logic [3:0] rq [0:15]; // received nibbles
	mpg_port dut (.*);
	mpg_phy_model phy (.*);
	always #5 clock = ~clock;
	// collect each received nibble strobe
	always @(posedge clock)
		if (rx_valid === 1'b1 && rn < 16)
		begin
			rq[rn] = rx_data;
			rn++;
		end
	task finish_test;
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clock);
		{cs_n, iowr_n, addr, wdata} = {2'b00, a, d};
		@(negedge clock);
		{cs_n, iowr_n} = 2'b11;
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e);
		@(negedge clock);
		{cs_n, iord_n, addr} = {2'b00, a};
		@(negedge clock);
		{cs_n, iord_n} = 2'b11;
		chk(rdata, e);
	endtask
	// offer one nibble and hold it until the edge that takes it
	task nib(input logic [3:0] d, input logic l);
		int n;
		logic ok;
		{tx_valid, tx_data, tx_last} = {1'b1, d, l};
		n = 0;
		do
		begin
			#1 ok = tx_ready;
			@(negedge clock);
			n++;
		end while (ok !== 1'b1 && n < 200);
		if (ok !== 1'b1)
		begin
			failures++;
			finish_test;
		end
	endtask
	initial
	begin
		repeat (3) @(negedge clock);
		srst = 0;
		repeat (8) @(negedge clock);
		chk(general_output_zero, 1);
		rd(5'h17, 8'h50);
		wr(5'h17, 8'h01);
		chk(general_output_zero, 0);
		rd(5'h17, 8'h51);
		wr(5'h17, 8'h00);
		chk(general_output_zero, 1);
		rd(5'h05, 8'h00);
		wr(5'h14, 8'h07);
		chk(mdc, 1);
		repeat (20) @(negedge clock); // each mdc level lasts over 200 ns
		rd(5'h14, 8'h0f);
		wr(5'h14, 8'h04);
		chk(mdc, 0);
		repeat (20) @(negedge clock);
		rd(5'h14, 8'h04);
		wr(5'h1b, 8'h01);
		chk(printer_port, 1);
		rd(5'h17, 8'h40);
		chk({printer_online_input, media_empty_input}, 2'b10);
		wr(5'h1b, 8'h00);
		{crs, col} = 2'b11;
		repeat (8) @(negedge clock);
		chk({carrier, collision}, 2'b11);
		duplex_status_input = 1; // full duplex masks collision
		repeat (8) @(negedge clock);
		chk(collision, 0);
		rd(5'h17, 8'h70);
		{crs, col} = 2'b00;
		for (i = 0; i < 4; i++)
			nib(4'h5 + i[3:0], i == 3);
		tx_valid = 0;
		i = 0;
		while (phy.tn < 4 && i < 3000)
		begin
			@(negedge clock);
			i++;
		end
		// a frame that never reaches the phy is a mismatch
		if (phy.tn < 4)
		begin
			failures++;
			finish_test;
		end
		for (i = 0; i < 4; i++)
			chk(phy.txq[i], 4'h5 + i[3:0]);
		phy.send(3);
		repeat (40) @(negedge clock); // frame ended, strobes drained
		chk(rn, 3);
		for (i = 0; i < 3; i++)
			chk(rq[i], 4'ha ^ i[3:0]);
		finish_test;
	end
endmodule
